// file: verilog/eqc_pkg.sv
// eqc_pkg: register map, field layout, reset values and table layout
// for the coefficient indirect access block.
// assumes one 100 MHz processing clock and a synchronous reset.
package eqc_pkg;
    localparam int COEF_W = 20;
    localparam int COEF_DEPTH = 69;
    localparam int IDX_W = 7;

    // register offsets, same numbers on the 16-bit link and as byte addresses
    localparam logic [7:0] OFS_EQ_CTRL = 8'h70;
    localparam logic [7:0] OFS_BASS_CTRL = 8'h72;
    localparam logic [7:0] OFS_DATA_LOW = 8'h78;
    localparam logic [7:0] OFS_DATA_LOW_LO = 8'h79;
    localparam logic [7:0] OFS_CTRL_UP = 8'h7A;
    localparam logic [7:0] OFS_CTRL_UP_LO = 8'h7B;

    // coefficient address = index + base
    localparam logic [7:0] COEF_BASE = 8'h40;

    localparam int BIT_STATIC_EQ = 0;
    localparam int BIT_SIDE_FIRE = 1;
    localparam int BIT_REDIRECT = 0;

    // table regions by index
    localparam logic [IDX_W-1:0] IDX_SURR_FIRST = 7'd20;
    localparam logic [IDX_W-1:0] IDX_SUB_FIRST = 7'd40;
    localparam logic [IDX_W-1:0] IDX_SCALE_FIRST = 7'd60;
    localparam logic [IDX_W-1:0] IDX_REDIR_FIRST = 7'd63;
    localparam logic [IDX_W-1:0] IDX_LAST = 7'd68;

    localparam logic [15:0] RST_REG16 = 16'h0000;
    localparam logic [19:0] RST_COEF = 20'h0_0000;
    localparam logic [19:0] RST_SCALE = 20'h8_0000;
    localparam logic [19:0] RST_REDIR = 20'hC_0000;

    typedef struct packed {
        logic [7:0] addr;
        logic [2:0] spare;
        logic rd_sel;
        logic [3:0] upper;
    } eqc_ctrl_t;

    typedef enum logic [2:0] {
        K_FRONT, K_SURR, K_SUB, K_SCALE, K_REDIR, K_NONE
    } eqc_kind_t;

    function automatic eqc_kind_t eqc_kind(input logic [IDX_W-1:0] idx);
        if (idx < IDX_SURR_FIRST) return K_FRONT;
        else if (idx < IDX_SUB_FIRST) return K_SURR;
        else if (idx < IDX_SCALE_FIRST) return K_SUB;
        else if (idx < IDX_REDIR_FIRST) return K_SCALE;
        else if (idx <= IDX_LAST) return K_REDIR;
        else return K_NONE;
    endfunction : eqc_kind

    function automatic logic [19:0] eqc_default(input int idx);
        case (idx)
            40: return 20'h0_0032;
            41: return 20'h8_0032;
            42: return 20'h7_C7EA;
            43: return 20'h8_1C6F;
            44: return 20'h0_0032;
            60, 61, 62, 68: return RST_SCALE;
            63, 64, 65, 66, 67: return RST_REDIR;
            default: return RST_COEF;
        endcase
    endfunction : eqc_default
endpackage : eqc_pkg

// file: verilog/eqc_coef_access.sv
// eqc_coef_access: coefficient table behind an indirect access port, reached
// as 16-bit link registers or as byte registers, plus the eq enables.
// assumes host strobes are one-cycle pulses synchronous to I_CLK.
`timescale 1ns/1ns
module eqc_coef_access import eqc_pkg::*; #(
    parameter int DEPTH = COEF_DEPTH
) (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_W16,
    input wire logic I_R16,
    input wire logic [7:0] I_A16,
    input wire logic [15:0] I_WD16,
    output logic [15:0] O_RD16,
    input wire logic I_W8,
    input wire logic I_R8,
    input wire logic [7:0] I_A8,
    input wire logic [7:0] I_WD8,
    output logic [7:0] O_RD8,
    input wire logic [IDX_W-1:0] I_COEF_IDX,
    output logic signed [COEF_W-1:0] O_COEF,
    output eqc_kind_t O_COEF_KIND,
    output logic O_STATIC_EQ,
    output logic O_SIDE_FIRE,
    output logic O_REDIRECT
);
    logic [COEF_W-1:0] ram [DEPTH];
    logic [15:0] data_low;
    eqc_ctrl_t ctrl;
    logic [15:0] eq_ctrl;
    logic [15:0] bass_ctrl;

    // decode; a 16-bit write wins over a byte write in the same cycle
    wire logic w16_low = I_W16 && I_A16 == OFS_DATA_LOW;
    wire logic w16_ctl = I_W16 && I_A16 == OFS_CTRL_UP;
    wire logic w8_hi = I_W8 && !I_W16 && I_A8 == OFS_DATA_LOW;
    wire logic w8_lo = I_W8 && !I_W16 && I_A8 == OFS_DATA_LOW_LO;
    wire logic w8_addr = I_W8 && !I_W16 && I_A8 == OFS_CTRL_UP;
    wire logic w8_ctl = I_W8 && !I_W16 && I_A8 == OFS_CTRL_UP_LO;
    // start only on the top register
    wire logic go = w16_ctl || w8_ctl;
    // byte at odd address replaces the low half of 7Ah
    wire eqc_ctrl_t next_ctrl = w16_ctl ? eqc_ctrl_t'(I_WD16) : eqc_ctrl_t'({ctrl.addr, I_WD8});
    // table address from the high byte, less the base
    wire logic [7:0] off = next_ctrl.addr - COEF_BASE;
    wire logic idx_ok = next_ctrl.addr >= COEF_BASE && off < 8'(DEPTH);
    wire logic [IDX_W-1:0] idx = off[IDX_W-1:0];
    wire logic [COEF_W-1:0] rd_word = ram[idx];
    wire logic [COEF_W-1:0] wr_word = {next_ctrl.upper, data_low};
    wire logic do_rd = go && idx_ok && next_ctrl.rd_sel;
    wire logic do_wr = go && idx_ok && !next_ctrl.rd_sel;
    wire logic fetch_ok = I_COEF_IDX < IDX_W'(DEPTH);

    // byte lanes of the 16-bit registers
    wire logic [15:0] rd16_mux =
        I_A16 == OFS_DATA_LOW ? data_low :
        I_A16 == OFS_CTRL_UP ? ctrl :
        I_A16 == OFS_EQ_CTRL ? eq_ctrl :
        I_A16 == OFS_BASS_CTRL ? bass_ctrl : 16'h0000;
    wire logic [7:0] a8_even = {I_A8[7:1], 1'b0};
    wire logic [15:0] rd8_word =
        a8_even == OFS_DATA_LOW ? data_low :
        a8_even == OFS_CTRL_UP ? ctrl :
        a8_even == OFS_EQ_CTRL ? eq_ctrl :
        a8_even == OFS_BASS_CTRL ? bass_ctrl : 16'h0000;
    // even byte is the high half
    wire logic [7:0] rd8_mux = I_A8[0] ? rd8_word[7:0] : rd8_word[15:8];

    // data-low: host load or read result
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            data_low <= RST_REG16;
        end else if (do_rd) begin
            data_low <= rd_word[15:0];
        end else if (w16_low) begin
            data_low <= I_WD16;
        end else if (w8_hi) begin
            data_low[15:8] <= I_WD8;
        end else if (w8_lo) begin
            data_low[7:0] <= I_WD8;
        end
    end

    // upper nibble written by host or loaded by a read
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            ctrl <= eqc_ctrl_t'(RST_REG16);
        end else if (go) begin
            ctrl <= next_ctrl;
            if (do_rd) begin
                ctrl.upper <= rd_word[19:16];
            end
        end else if (w8_addr) begin
            ctrl.addr <= I_WD8;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            for (int i = 0; i < DEPTH; i++) begin
                ram[i] <= eqc_default(i);
            end
        end else if (do_wr) begin
            ram[idx] <= wr_word;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            eq_ctrl <= RST_REG16;
            bass_ctrl <= RST_REG16;
        end else if (I_W16) begin
            if (I_A16 == OFS_EQ_CTRL) begin
                eq_ctrl <= I_WD16;
            end
            if (I_A16 == OFS_BASS_CTRL) begin
                bass_ctrl <= I_WD16;
            end
        end else if (I_W8) begin
            case (I_A8)
                OFS_EQ_CTRL: eq_ctrl[15:8] <= I_WD8;
                OFS_EQ_CTRL + 8'h01: eq_ctrl[7:0] <= I_WD8;
                OFS_BASS_CTRL: bass_ctrl[15:8] <= I_WD8;
                OFS_BASS_CTRL + 8'h01: bass_ctrl[7:0] <= I_WD8;
                default: ;
            endcase
        end
    end

    // read data is held until the next read strobe
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_RD16 <= 16'h0000;
            O_RD8 <= 8'h00;
        end else begin
            if (I_R16) begin
                O_RD16 <= rd16_mux;
            end
            if (I_R8) begin
                O_RD8 <= rd8_mux;
            end
        end
    end

    // front and surround sets live once in the table, shared by each pair
    // region tag tells the filter engine what the word is
    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_COEF <= '0;
            O_COEF_KIND <= K_NONE;
        end else begin
            // word passed as a signed fraction
            O_COEF <= fetch_ok ? signed'(ram[I_COEF_IDX]) : '0;
            // scale words tagged for use ahead of the filters
            // redirection words tagged for the subwoofer sum
            O_COEF_KIND <= eqc_kind(I_COEF_IDX);
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            O_STATIC_EQ <= 1'b0;
            O_SIDE_FIRE <= 1'b0;
            O_REDIRECT <= 1'b0;
        end else begin
            O_STATIC_EQ <= eq_ctrl[BIT_STATIC_EQ];
            O_SIDE_FIRE <= eq_ctrl[BIT_SIDE_FIRE];
            O_REDIRECT <= bass_ctrl[BIT_REDIRECT];
        end
    end

    // checking helpers
    logic [IDX_W-1:0] chk_idx;
    logic [COEF_W-1:0] chk_word;
    logic chk_wr;
    always_ff @(posedge I_CLK) begin
        chk_idx <= idx;
        chk_word <= wr_word;
        chk_wr <= do_wr && !I_SRST;
    end
    wire logic [COEF_W-1:0] chk_ram = ram[chk_idx];

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);

    range_fetch_a: assert property (
        !fetch_ok |=> O_COEF == '0 && O_COEF_KIND == K_NONE)
        else $error("fetch beyond table not zero");
    read_low_a: assert property (
        do_rd |=> data_low == $past(rd_word[15:0]))
        else $error("read did not load data-low");
    read_upper_a: assert property (
        do_rd |=> ctrl.upper == $past(rd_word[19:16]) && ctrl.rd_sel)
        else $error("read did not load upper nibble");
    addr_byte_a: assert property (
        w8_addr |=> ctrl.addr == $past(I_WD8) && $stable(ctrl.upper))
        else $error("address byte not held");
    write_store_a: assert property (
        chk_wr |-> chk_ram == chk_word)
        else $error("write did not reach table");
    no_start_a: assert property (
        !go && !w16_low && !w8_hi && !w8_lo |=> $stable(data_low))
        else $error("data-low moved without a transfer");
    byte_lane_a: assert property (
        I_R8 && I_A8 == OFS_DATA_LOW |=> O_RD8 == $past(data_low[15:8]))
        else $error("byte 78h lane wrong");
    bad_index_a: assert property (
        go && !idx_ok |=> $stable(data_low) && ctrl.upper == $past(next_ctrl.upper))
        else $error("bad index changed data");
    redirect_gate_a: assert property (
        ##1 O_REDIRECT == $past(bass_ctrl[BIT_REDIRECT]))
        else $error("redirect gate wrong");
endmodule : eqc_coef_access

// file: testbench/eqc_host.sv
// eqc_host: host controller model for the link and byte register ports.
// assumes strobes are taken at rising i_clk, read data lands next cycle.
`timescale 1ns/1ns
module eqc_host (
    input wire logic i_clk,
    input wire logic [15:0] i_rd16,
    input wire logic [7:0] i_rd8,
    output logic o_w16,
    output logic o_r16,
    output logic [7:0] o_a16,
    output logic [15:0] o_wd16,
    output logic o_w8,
    output logic o_r8,
    output logic [7:0] o_a8,
    output logic [7:0] o_wd8
);
    initial begin
        {o_w16, o_r16, o_w8, o_r8} = 4'h0;
        {o_a16, o_wd16, o_a8, o_wd8} = '1;
    end

    task automatic acc16(input logic wr, input logic [7:0] a, input logic [15:0] d,
                         output logic [15:0] q);
        @(posedge i_clk);
        o_w16 <= wr;
        o_r16 <= !wr;
        o_a16 <= a;
        o_wd16 <= d;
        @(posedge i_clk);
        o_w16 <= 1'b0;
        o_r16 <= 1'b0;
        // released lines must not keep the old value
        o_a16 <= ~a;
        o_wd16 <= ~d;
        #1 q = i_rd16;
    endtask : acc16

    task automatic acc8(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(posedge i_clk);
        o_w8 <= wr;
        o_r8 <= !wr;
        o_a8 <= a;
        o_wd8 <= d;
        @(posedge i_clk);
        o_w8 <= 1'b0;
        o_r8 <= 1'b0;
        o_a8 <= ~a;
        o_wd8 <= ~d;
        #1 q = i_rd8;
    endtask : acc8
endmodule : eqc_host

// file: testbench/eq_coefficient_indirect_access_test.sv
// testbench for eqc_coef_access: sequences of register calls with expected values.
// assumes 100 MHz clock, synchronous active-high reset held two cycles.
`timescale 1ns/1ns
module eq_coefficient_indirect_access_test;
    import eqc_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [IDX_W-1:0] idx = 7'h00;
    wire w16, r16, w8, r8;
    wire [7:0] a16, a8, wd8, rd8;
    wire [15:0] wd16, rd16;
    logic signed [COEF_W-1:0] coef;
    eqc_kind_t kind;
    logic static_eq, side_fire, redirect;
    logic [15:0] q;
    logic [7:0] q8;
    int failures = 0;
    int check_count = 0;
    logic [6:0] ti [9] = '{7'h00, 7'h13, 7'h14, 7'h2A, 7'h3B, 7'h3E, 7'h3F, 7'h44, 7'h45};
    logic [19:0] tc [9] = '{20'h0_0000, 20'h0_0000, 20'h0_0000, 20'h7_C7EA, 20'h0_0000,
                           20'h8_0000, 20'hC_0000, 20'h8_0000, 20'h0_0000};
    eqc_kind_t tk [9] = '{K_FRONT, K_FRONT, K_SURR, K_SUB, K_SUB, K_SCALE, K_REDIR,
                          K_REDIR, K_NONE};

    always #5 clk = ~clk;

    eqc_coef_access uut (.I_CLK(clk), .I_SRST(srst), .I_W16(w16), .I_R16(r16),
        .I_A16(a16), .I_WD16(wd16), .O_RD16(rd16), .I_W8(w8), .I_R8(r8), .I_A8(a8),
        .I_WD8(wd8), .O_RD8(rd8), .I_COEF_IDX(idx), .O_COEF(coef), .O_COEF_KIND(kind),
        .O_STATIC_EQ(static_eq), .O_SIDE_FIRE(side_fire), .O_REDIRECT(redirect));

    eqc_host host (.i_clk(clk), .i_rd16(rd16), .i_rd8(rd8), .o_w16(w16), .o_r16(r16),
        .o_a16(a16), .o_wd16(wd16), .o_w8(w8), .o_r8(r8), .o_a8(a8), .o_wd8(wd8));

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic w16x(input logic [7:0] a, input logic [15:0] d);
        host.acc16(1'b1, a, d, q);
    endtask : w16x

    task automatic r16x(input logic [7:0] a, input logic [15:0] e);
        host.acc16(1'b0, a, 16'h0000, q);
        chk({4'h0, q}, {4'h0, e});
    endtask : r16x

    task automatic w8x(input logic [7:0] a, input logic [7:0] d);
        host.acc8(1'b1, a, d, q8);
    endtask : w8x

    task automatic r8x(input logic [7:0] a, input logic [7:0] e);
        host.acc8(1'b0, a, 8'h00, q8);
        chk({12'h000, q8}, {12'h000, e});
    endtask : r8x

    task automatic fetch(input logic [6:0] i, input logic [19:0] e, input eqc_kind_t k);
        @(posedge clk);
        idx <= i;
        @(posedge clk);
        #1;
        chk(coef, e);
        chk({17'h0_0000, kind}, {17'h0_0000, k});
    endtask : fetch

    task automatic flags(input logic [2:0] e);
        repeat (2) @(posedge clk);
        #1;
        chk({17'h0_0000, static_eq, side_fire, redirect}, {17'h0_0000, e});
    endtask : flags

    task automatic final_report;
        if (failures == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        r16x(OFS_EQ_CTRL, 16'h0000);
        r16x(OFS_CTRL_UP, 16'h0000);
        for (int n = 0; n < 9; n++) fetch(ti[n], tc[n], tk[n]);
        w16x(OFS_CTRL_UP, 16'h6A10);
        r16x(OFS_DATA_LOW, 16'hC7EA);
        r16x(OFS_CTRL_UP, 16'h6A17);
        w16x(OFS_DATA_LOW, 16'h1234);
        w16x(OFS_CTRL_UP, 16'h450A);
        fetch(7'h05, 20'hA_1234, K_FRONT);
        w8x(OFS_DATA_LOW, 8'h56);
        w8x(OFS_DATA_LOW_LO, 8'h78);
        w8x(OFS_CTRL_UP, 8'h7F);
        fetch(7'h3F, 20'hC_0000, K_REDIR);
        w8x(OFS_CTRL_UP_LO, 8'h03);
        fetch(7'h3F, 20'h3_5678, K_REDIR);
        w8x(OFS_CTRL_UP, 8'h7F);
        w8x(OFS_CTRL_UP_LO, 8'h10);
        r8x(OFS_DATA_LOW, 8'h56);
        r8x(OFS_DATA_LOW_LO, 8'h78);
        r8x(OFS_CTRL_UP_LO, 8'h13);
        w16x(OFS_DATA_LOW, 16'hFFFF);
        w16x(OFS_CTRL_UP, 16'h850F);
        fetch(7'h44, 20'h8_0000, K_REDIR);
        r16x(OFS_DATA_LOW, 16'hFFFF);
        w16x(OFS_CTRL_UP, 16'h3F10);
        r16x(OFS_DATA_LOW, 16'hFFFF);
        r16x(OFS_CTRL_UP, 16'h3F10);
        w16x(OFS_EQ_CTRL, 16'h0003);
        w16x(OFS_BASS_CTRL, 16'h0001);
        flags(3'h7);
        r8x(8'h71, 8'h03);
        r8x(8'h70, 8'h00);
        r16x(8'h74, 16'h0000);
        w16x(OFS_BASS_CTRL, 16'h0000);
        w16x(OFS_EQ_CTRL, 16'h0002);
        flags(3'h2);
        w8x(8'h73, 8'h01);
        w8x(8'h71, 8'h01);
        flags(3'h5);
        w16x(OFS_DATA_LOW, 16'h0000);
        w16x(OFS_CTRL_UP, 16'h7C0C);
        fetch(7'h3C, 20'hC_0000, K_SCALE);
        // second reset mid-run must restore table defaults and clear enables
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        flags(3'h0);
        fetch(7'h3C, 20'h8_0000, K_SCALE);
        fetch(7'h3F, 20'hC_0000, K_REDIR);
        r16x(OFS_CTRL_UP, 16'h0000);
        final_report();
    end

    // whole sequence needs well under 400 cycles
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        final_report();
    end
endmodule : eq_coefficient_indirect_access_test
